// [verilog/bridge_ctrl_pkg.sv]
/*
 * Constants shared by the bridge command decoder and its link-side front.
 * Assumes a 250 MHz system clock and a byte-level two-wire slave in front.
 */
`default_nettype none
package bridge_ctrl_pkg;
	// ==========================================================
	// Function codes
	localparam logic [7:0] CODE_SPI_SETUP = 8'hF0;
	localparam logic [7:0] CODE_INT_CLEAR = 8'hF1;
	localparam logic [7:0] CODE_IDLE = 8'hF2;
	localparam logic [7:0] CODE_PIN_WRITE = 8'hF4;
	localparam logic [7:0] CODE_PIN_SAMPLE = 8'hF5;
	localparam logic [7:0] CODE_PIN_ENABLE = 8'hF6;
	localparam logic [7:0] CODE_XFER_FIRST = 8'h01;
	localparam logic [7:0] CODE_XFER_LAST = 8'h0F;
	// ==========================================================
	// Setup byte fields and select pin count
	localparam int ORDER_BIT = 5;
	localparam int SHAPE_LSB = 2;
	localparam int RATE_LSB = 0;
	localparam int PIN_COUNT = 4;
	// ==========================================================
	// Reset values
	localparam logic ORDER_RESET = 1'b0;
	localparam logic [1:0] SHAPE_RESET = 2'h0;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam logic [3:0] PIN_ENABLE_RESET = 4'h0;
	localparam logic [3:0] PIN_LATCH_RESET = 4'h0;
	// ==========================================================
	// Serial clock rates in Hz and half periods in system cycles
	localparam int SYS_CLK_HZ = 250_000_000;
	localparam int RATE0_HZ = 1_843_000;
	localparam int RATE1_HZ = 461_000;
	localparam int RATE2_HZ = 115_000;
	localparam int RATE3_HZ = 58_000;
	localparam logic [11:0] HALF0_CYC = 12'(SYS_CLK_HZ / (2 * RATE0_HZ));
	localparam logic [11:0] HALF1_CYC = 12'(SYS_CLK_HZ / (2 * RATE1_HZ));
	localparam logic [11:0] HALF2_CYC = 12'(SYS_CLK_HZ / (2 * RATE2_HZ));
	localparam logic [11:0] HALF3_CYC = 12'(SYS_CLK_HZ / (2 * RATE3_HZ));
	// ==========================================================
	// Decoder states
	typedef enum logic [3:0] {
		ST_READY = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_SPI = 4'b0100,
		ST_ACK = 4'b1000
	} exec_state_t;
endpackage
`default_nettype wire

// [verilog/bridge_link_front.sv]
/*
 * Link-clock side: gathers function code, first data byte and byte count of
 * one write message and hands them over by toggle. Assumes the slave front
 * end gives byte strobes on the link clock.
 */
`timescale 1ns/10ps
`default_nettype none
module bridge_link_front (
	input wire logic link_clk_in,
	input wire logic rst_n_in,
	input wire logic addr_hit_in,
	input wire logic addr_write_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire logic stop_in,
	input wire logic ack_tgl_in,
	output logic busy_out,
	output logic cmd_tgl_out,
	output logic wake_tgl_out,
	output logic [7:0] code_out,
	output logic [7:0] data_out,
	output logic [7:0] count_out
);
	import bridge_ctrl_pkg::*;

	// ==========================================================
	// Synchronisers
	logic rst_s1_q, rst_s2_q, ack_s1_q, ack_s2_q;
	always_ff @(posedge link_clk_in) begin
		rst_s1_q <= rst_n_in;
		rst_s2_q <= rst_s1_q;
		ack_s1_q <= ack_tgl_in;
		ack_s2_q <= ack_s1_q;
	end

	// ==========================================================
	// Message capture
	logic in_msg_q, in_msg_d, have_code_q, have_code_d, busy_d, cmd_tgl_d, wake_tgl_d, ack_seen_q, ack_seen_d;
	logic [7:0] code_d, data_d, count_d;
	always_comb begin
		in_msg_d = in_msg_q;
		have_code_d = have_code_q;
		busy_d = busy_out;
		cmd_tgl_d = cmd_tgl_out;
		wake_tgl_d = wake_tgl_out;
		ack_seen_d = ack_s2_q;
		code_d = code_out;
		data_d = data_out;
		count_d = count_out;
		if (ack_s2_q != ack_seen_q)
			busy_d = 1'b0;
		if (addr_hit_in) begin
			wake_tgl_d = ~wake_tgl_out;
			// While busy the front end refuses the address; only the wake toggle flips
			if (!busy_out && addr_write_in) begin
				in_msg_d = 1'b1;
				have_code_d = 1'b0;
				count_d = 8'h00;
			end
		end else if (byte_valid_in && in_msg_q) begin
			if (!have_code_q) begin
				code_d = byte_in;
				have_code_d = 1'b1;
			end else begin
				if (count_out == 8'h00)
					data_d = byte_in;
				if (count_out != 8'hFF)
					count_d = count_out + 8'h01;
			end
		end
		if (stop_in && in_msg_q) begin
			in_msg_d = 1'b0;
			if (have_code_q) begin
				busy_d = 1'b1;
				cmd_tgl_d = ~cmd_tgl_out;
			end
		end
	end

	always_ff @(posedge link_clk_in) begin
		if (!rst_s2_q) begin
			in_msg_q <= 1'b0;
			have_code_q <= 1'b0;
			busy_out <= 1'b0;
			cmd_tgl_out <= 1'b0;
			wake_tgl_out <= 1'b0;
			ack_seen_q <= 1'b0;
			code_out <= 8'h00;
			data_out <= 8'h00;
			count_out <= 8'h00;
		end else begin
			in_msg_q <= in_msg_d;
			have_code_q <= have_code_d;
			busy_out <= busy_d;
			cmd_tgl_out <= cmd_tgl_d;
			wake_tgl_out <= wake_tgl_d;
			ack_seen_q <= ack_seen_d;
			code_out <= code_d;
			data_out <= data_d;
			count_out <= count_d;
		end
	end
endmodule
`default_nettype wire

// [verilog/bridge_control.sv]
/*
 * Command decoder of a two-wire to SPI bridge: applies setup, interrupt,
 * idle and select-pin functions and launches SPI transfers. Assumes an
 * external SPI engine on the system clock and a two-wire slave front end
 * on the link clock that refuses its address while busy_out is high.
 */
`timescale 1ns/10ps
`default_nettype none
module bridge_control (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	input wire logic addr_hit_in,
	input wire logic addr_write_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire logic stop_in,
	output logic busy_out,
	input wire logic spi_done_in,
	output logic spi_start_out,
	output logic [3:0] spi_select_mask_out,
	output logic [7:0] spi_byte_count_out,
	output logic spi_lsb_first_out,
	output logic [1:0] clock_shape_code_out,
	output logic [1:0] clock_rate_code_out,
	output logic serial_clock_idle_high_out,
	output logic sample_trailing_out,
	output logic [11:0] serial_clock_half_out,
	output logic int_n_out,
	output logic idle_out,
	output logic [7:0] sample_byte_out,
	output logic sample_write_out,
	input wire logic [bridge_ctrl_pkg::PIN_COUNT-1:0] select_line_in,
	output logic [bridge_ctrl_pkg::PIN_COUNT-1:0] select_line_out,
	output logic [bridge_ctrl_pkg::PIN_COUNT-1:0] select_line_oe_out,
	output logic [bridge_ctrl_pkg::PIN_COUNT-1:0] pin_quasi_out
);
	import bridge_ctrl_pkg::*;

	// ==========================================================
	// Link-side front and crossings
	logic link_cmd_tgl, link_wake_tgl, ack_tgl_q, ack_tgl_d;
	logic [7:0] link_code, link_data, link_count;

	bridge_link_front u_front (
		.link_clk_in(link_clk_in),
		.rst_n_in(rst_n_in),
		.addr_hit_in(addr_hit_in),
		.addr_write_in(addr_write_in),
		.byte_valid_in(byte_valid_in),
		.byte_in(byte_in),
		.stop_in(stop_in),
		.ack_tgl_in(ack_tgl_q),
		.busy_out(busy_out),
		.cmd_tgl_out(link_cmd_tgl),
		.wake_tgl_out(link_wake_tgl),
		.code_out(link_code),
		.data_out(link_data),
		.count_out(link_count)
	);

	// Code, data and count stay still while the front is busy, so they are
	// taken as words once the toggle has passed its two flops.
	logic cmd_s1_q, cmd_s2_q, cmd_s3_q, wake_s1_q, wake_s2_q, wake_s3_q;
	logic [PIN_COUNT-1:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge clk_sys_in) begin
		cmd_s1_q <= link_cmd_tgl;
		cmd_s2_q <= cmd_s1_q;
		cmd_s3_q <= cmd_s2_q;
		wake_s1_q <= link_wake_tgl;
		wake_s2_q <= wake_s1_q;
		wake_s3_q <= wake_s2_q;
		pin_s1_q <= select_line_in;
		pin_s2_q <= pin_s1_q;
	end

	logic cmd_new, wake_new;
	assign cmd_new = cmd_s2_q ^ cmd_s3_q;
	assign wake_new = wake_s2_q ^ wake_s3_q;

	// ==========================================================
	// Decode
	logic is_xfer, has_data, no_data;
	assign is_xfer = (link_code >= CODE_XFER_FIRST) && (link_code <= CODE_XFER_LAST);
	assign has_data = (link_count == 8'h01);
	assign no_data = (link_count == 8'h00);

	// ==========================================================
	// Sequencer and configuration state
	exec_state_t state_q, state_d;
	logic order_q, order_d, int_n_d, idle_d, start_d, samp_wr_d;
	logic [1:0] shape_q, shape_d, rate_q, rate_d;
	logic [3:0] mask_q, mask_d, enable_q, enable_d, latch_q, latch_d, quasi_d;
	logic [7:0] count_q, count_d, samp_d;

	always_comb begin
		state_d = state_q;
		order_d = order_q;
		shape_d = shape_q;
		rate_d = rate_q;
		int_n_d = int_n_out;
		idle_d = idle_out;
		start_d = 1'b0;
		samp_wr_d = 1'b0;
		samp_d = sample_byte_out;
		mask_d = mask_q;
		count_d = count_q;
		enable_d = enable_q;
		latch_d = latch_q;
		quasi_d = pin_quasi_out;
		ack_tgl_d = ack_tgl_q;
		if (wake_new)
			idle_d = 1'b0;
		case (state_q)
			ST_READY: begin
				if (cmd_new)
					state_d = ST_EXEC;
			end
			ST_EXEC: begin
				state_d = ST_ACK;
				if (is_xfer) begin
					mask_d = link_code[PIN_COUNT-1:0];
					count_d = link_count;
					start_d = 1'b1;
					state_d = ST_SPI;
				end else if (link_code == CODE_SPI_SETUP && has_data) begin
					order_d = link_data[ORDER_BIT];
					shape_d = link_data[SHAPE_LSB+1:SHAPE_LSB];
					rate_d = link_data[RATE_LSB+1:RATE_LSB];
				end else if (link_code == CODE_INT_CLEAR && no_data) begin
					int_n_d = 1'b1;
				end else if (link_code == CODE_IDLE) begin
					idle_d = 1'b1;
				end else if (link_code == CODE_PIN_WRITE && has_data) begin
					// Only pins already in GPIO duty take the new level
					latch_d = (latch_q & ~enable_q) | (link_data[3:0] & enable_q);
				end else if (link_code == CODE_PIN_SAMPLE) begin
					// Upper nibble and select-duty bits carry no meaning
					samp_d = {4'h0, pin_s2_q};
					samp_wr_d = 1'b1;
				end else if (link_code == CODE_PIN_ENABLE && has_data) begin
					enable_d = link_data[3:0];
					quasi_d = pin_quasi_out | (link_data[3:0] & ~enable_q);
				end
			end
			ST_SPI: begin
				if (spi_done_in) begin
					// Stays low until cleared; polling hosts never clear it
					int_n_d = 1'b0;
					state_d = ST_ACK;
				end
			end
			ST_ACK: begin
				ack_tgl_d = ~ack_tgl_q;
				state_d = ST_READY;
			end
			default: state_d = ST_READY;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_q <= ST_READY;
			order_q <= ORDER_RESET;
			shape_q <= SHAPE_RESET;
			rate_q <= RATE_RESET;
			int_n_out <= 1'b1;
			idle_out <= 1'b0;
			spi_start_out <= 1'b0;
			sample_write_out <= 1'b0;
			sample_byte_out <= 8'h00;
			mask_q <= 4'h0;
			count_q <= 8'h00;
			enable_q <= PIN_ENABLE_RESET;
			latch_q <= PIN_LATCH_RESET;
			pin_quasi_out <= 4'h0;
			ack_tgl_q <= 1'b0;
		end else begin
			state_q <= state_d;
			order_q <= order_d;
			shape_q <= shape_d;
			rate_q <= rate_d;
			int_n_out <= int_n_d;
			idle_out <= idle_d;
			spi_start_out <= start_d;
			sample_write_out <= samp_wr_d;
			sample_byte_out <= samp_d;
			mask_q <= mask_d;
			count_q <= count_d;
			enable_q <= enable_d;
			latch_q <= latch_d;
			pin_quasi_out <= quasi_d;
			ack_tgl_q <= ack_tgl_d;
		end
	end

	// ==========================================================
	// Registered engine settings and pin drive
	logic [11:0] half_d;
	logic [3:0] pin_out_d, pin_oe_d;
	always_comb begin
		case (rate_q)
			2'h0: half_d = HALF0_CYC;
			2'h1: half_d = HALF1_CYC;
			2'h2: half_d = HALF2_CYC;
			default: half_d = HALF3_CYC;
		endcase
		for (int i = 0; i < PIN_COUNT; i++) begin
			if (enable_q[i]) begin
				// Quasi pin: strong low only, high left to the weak pull-up
				pin_out_d[i] = 1'b0;
				pin_oe_d[i] = ~latch_q[i];
			end else begin
				pin_out_d[i] = ~(mask_q[i] && state_q == ST_SPI);
				pin_oe_d[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			spi_select_mask_out <= 4'h0;
			spi_byte_count_out <= 8'h00;
			spi_lsb_first_out <= ORDER_RESET;
			clock_shape_code_out <= SHAPE_RESET;
			clock_rate_code_out <= RATE_RESET;
			serial_clock_idle_high_out <= 1'b0;
			sample_trailing_out <= 1'b0;
			serial_clock_half_out <= HALF0_CYC;
			select_line_out <= 4'hF;
			select_line_oe_out <= 4'hF;
		end else begin
			// Taken from the next values so mask and count stand with the start pulse
			spi_select_mask_out <= mask_d;
			spi_byte_count_out <= count_d;
			spi_lsb_first_out <= order_q;
			clock_shape_code_out <= shape_q;
			clock_rate_code_out <= rate_q;
			serial_clock_idle_high_out <= shape_q[1];
			sample_trailing_out <= shape_q[1] ^ shape_q[0];
			serial_clock_half_out <= half_d;
			select_line_out <= pin_out_d;
			select_line_oe_out <= pin_oe_d;
		end
	end
endmodule
`default_nettype wire

// [verification/bridge_control_monitor.sv]
/* Port checker for the bridge command decoder.
   Assumes the system clock and its synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module bridge_control_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic busy_out,
	input wire logic spi_done_in,
	input wire logic spi_start_out,
	input wire logic [3:0] spi_select_mask_out,
	input wire logic [1:0] clock_shape_code_out,
	input wire logic [1:0] clock_rate_code_out,
	input wire logic sample_trailing_out,
	input wire logic serial_clock_idle_high_out,
	input wire logic [11:0] serial_clock_half_out,
	input wire logic int_n_out,
	input wire logic idle_out,
	input wire logic [7:0] sample_byte_out,
	input wire logic sample_write_out,
	input wire logic [3:0] select_line_out,
	input wire logic [3:0] select_line_oe_out,
	input wire logic [3:0] pin_quasi_out
);
	import bridge_ctrl_pkg::*;
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// Setup only moves while busy is high, so derived outputs must match once it is low
	a_shape_decode: assert property (!busy_out |-> serial_clock_idle_high_out == clock_shape_code_out[1]
		&& sample_trailing_out == ^clock_shape_code_out) else $error("clock shape decode wrong");
	a_rate_half: assert property (!busy_out |-> serial_clock_half_out == (clock_rate_code_out[1] ?
		(clock_rate_code_out[0] ? HALF3_CYC : HALF2_CYC) : (clock_rate_code_out[0] ? HALF1_CYC : HALF0_CYC)))
		else $error("clock half period wrong");
	a_reset_state: assert property (disable iff (1'b0) !rst_n_in |=> int_n_out && !idle_out
		&& select_line_oe_out == 4'hF && clock_shape_code_out == 2'h0 && clock_rate_code_out == 2'h0)
		else $error("reset state wrong");
	a_int_on_done: assert property ($fell(int_n_out) |-> $past(spi_done_in)) else $error("interrupt without done");
	a_int_release: assert property ($rose(int_n_out) |-> busy_out) else $error("interrupt released uncommanded");
	a_start_pulse: assert property (spi_start_out |=> !spi_start_out) else $error("start not a pulse");
	a_start_select: assert property (spi_start_out |-> ##[0:2] (select_line_out & spi_select_mask_out) == 4'h0)
		else $error("selects not asserted");
	a_sample_pulse: assert property (sample_write_out |=> !sample_write_out && $stable(sample_byte_out))
		else $error("sample write wrong");
	a_quasi_sticky: assert property ((pin_quasi_out & $past(pin_quasi_out)) == $past(pin_quasi_out))
		else $error("quasi type lost");
endmodule
bind bridge_control bridge_control_monitor u_mon (.*);
`default_nettype wire

// [verification/spi_engine_model.sv]
/* Behavioural SPI engine that answers each start with a done pulse.
   Assumes start is a one-cycle pulse on the system clock. */
`timescale 1ns/10ps
`default_nettype none
module spi_engine_model (
	input wire logic clk_sys_in,
	input wire logic spi_start_in,
	input wire logic [7:0] delay_in,
	output logic spi_done_out
);
	initial spi_done_out = 1'b0;
	// Delay is set by the bench, so prompt and slow engines are both tried
	always @(posedge clk_sys_in) begin
		if (spi_start_in === 1'b1) begin
			repeat (delay_in) @(posedge clk_sys_in);
			spi_done_out <= 1'b1;
			@(posedge clk_sys_in);
			spi_done_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [verification/test_bridge_control.sv]
/* Self-checking bench for the bridge command decoder.
   Assumes the link front accepts one message at a time while not busy. */
`timescale 1ns/10ps
`default_nettype none
module test_bridge_control;
	import bridge_ctrl_pkg::*;
	logic clk_sys_in = 1'b0, link_clk_in = 1'b0, rst_n_in = 1'b0;
	logic addr_hit_in = 1'b0, addr_write_in = 1'b0, byte_valid_in = 1'b0, stop_in = 1'b0;
	logic [7:0] byte_in = 8'h00, rnd = 8'h48, dly = 8'h02;
	logic [3:0] ext = 4'hF;
	logic [4:0] cfg;
	logic busy_out, spi_done_in, spi_start_out, spi_lsb_first_out, serial_clock_idle_high_out;
	logic sample_trailing_out, int_n_out, idle_out, sample_write_out;
	logic [3:0] spi_select_mask_out, select_line_out, select_line_oe_out, pin_quasi_out;
	logic [1:0] clock_shape_code_out, clock_rate_code_out;
	logic [11:0] serial_clock_half_out;
	logic [7:0] spi_byte_count_out, sample_byte_out;
	logic [11:0] hv [4] = '{HALF0_CYC, HALF1_CYC, HALF2_CYC, HALF3_CYC};
	logic [11:0] q [$];
	wire logic [3:0] select_line_in;
	int n_fail = 0, checks = 0;
	// Undriven pins follow the outside level, which the bench randomises
	assign select_line_in = (select_line_oe_out & select_line_out) | (~select_line_oe_out & ext);
	always #2 clk_sys_in = ~clk_sys_in;
	always #40.01 link_clk_in = ~link_clk_in;
	bridge_control u_dut (.*);
	spi_engine_model u_spi (.clk_sys_in(clk_sys_in), .spi_start_in(spi_start_out), .delay_in(dly),
		.spi_done_out(spi_done_in));
	// ==========================================================
	// Tasks
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic stop_test();
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 200 && busy_out !== 1'b0; i++)
			@(posedge link_clk_in);
		if (i == 200) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic msg(input logic [7:0] code, input int n, input logic [7:0] d, input logic w);
		wait_idle();
		@(posedge link_clk_in);
		addr_hit_in <= 1'b1;
		addr_write_in <= w;
		@(posedge link_clk_in);
		addr_hit_in <= 1'b0;
		byte_valid_in <= w;
		byte_in <= code;
		repeat (w ? n : 0) begin
			@(posedge link_clk_in);
			byte_in <= d;
		end
		@(posedge link_clk_in);
		byte_valid_in <= 1'b0;
		byte_in <= ~byte_in;
		stop_in <= 1'b1;
		@(posedge link_clk_in);
		stop_in <= 1'b0;
		#1 cmp("busy", 12'(w), 12'(busy_out));
		wait_idle();
	endtask
	// ==========================================================
	// Result watcher
	always @(posedge clk_sys_in) begin
		if (spi_start_out === 1'b1)
			cmp("start", q.pop_front(), {spi_select_mask_out, spi_byte_count_out});
		if (sample_write_out === 1'b1)
			cmp("sample", q.pop_front(), {8'h0, sample_byte_out[3:0]});
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge link_clk_in);
		@(posedge clk_sys_in) rst_n_in <= 1'b1;
		repeat (4) @(posedge link_clk_in);
		cmp("reset", 12'hFF0, {select_line_oe_out, select_line_out, clock_shape_code_out, clock_rate_code_out});
		cmp("flags", 12'h8, {int_n_out, idle_out, spi_lsb_first_out, busy_out});
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			cfg = {rnd[5], i[1:0], ~i[1:0]};
			msg(CODE_SPI_SETUP, 1, {rnd[7:4], cfg[3:0]}, 1'b1);
			cmp("setup", 12'(cfg), {7'h0, spi_lsb_first_out, clock_shape_code_out, clock_rate_code_out});
			cmp("half", hv[3-i], serial_clock_half_out);
		end
		msg(8'hF3, 1, ~rnd, 1'b1);
		msg(CODE_SPI_SETUP, 2, ~rnd, 1'b1);
		cmp("ignored", 12'(cfg), {7'h0, spi_lsb_first_out, clock_shape_code_out, clock_rate_code_out});
		q.push_back({4'h5, 8'h03});
		msg(8'h05, 3, rnd, 1'b1);
		cmp("int", 12'h0, 12'(int_n_out));
		dly <= 8'h28;
		q.push_back({4'hF, 8'h01});
		msg(CODE_XFER_LAST, 1, rnd, 1'b1);
		msg(CODE_INT_CLEAR, 0, 8'h00, 1'b1);
		cmp("int", 12'h1, 12'(int_n_out));
		rnd = lfsr(rnd);
		msg(CODE_PIN_ENABLE, 1, {rnd[7:4], 4'hA}, 1'b1);
		cmp("quasi", 12'hA, 12'(pin_quasi_out));
		cmp("pins", 12'h0F5, {4'h0, select_line_oe_out, select_line_out});
		msg(CODE_PIN_WRITE, 1, {rnd[3:0], 4'hE}, 1'b1);
		cmp("pins", 12'h055, {4'h0, select_line_oe_out, select_line_out});
		@(posedge clk_sys_in) ext <= rnd[3:0];
		q.push_back({8'h0, rnd[3], 1'b1, rnd[1], 1'b1});
		msg(CODE_PIN_SAMPLE, 0, 8'h00, 1'b1);
		msg(CODE_PIN_ENABLE, 1, 8'hF0, 1'b1);
		cmp("pins", 12'h0FF, {4'h0, select_line_oe_out, select_line_out});
		msg(CODE_IDLE, 0, 8'h00, 1'b1);
		cmp("idle", 12'h1, 12'(idle_out));
		msg(8'h00, 0, 8'h00, 1'b0);
		cmp("idle", 12'h0, 12'(idle_out));
		cmp("queue", 12'h0, 12'(q.size()));
		stop_test();
	end
endmodule
`default_nettype wire
